// ===== logic/power_sequencer.sv
// Clock source choice and duty-cycled wake and sample timing
`timescale 1ns/100ps
`include "sensor_ctrl_cfg.svh"
module power_sequencer #(
  parameter int unsigned BASE_TICK_CYCLES = `BASE_TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  pwr_ctrl_if.seq ps
);
  logic [31:0] base_cnt_ff;
  logic [7:0] div_cnt_ff;
  logic wake_ff;
  logic sample_ff;
  logic use_pll_ff;
  logic stopped_ff;
  logic dozing_ff;
  logic stop_code;
  logic auto_code;
  logic run;
  logic base_end;
  logic tick_end;

  assign stop_code = ps.clk_sel == `CLOCK_SOURCE_SELECT_STOP;
  assign auto_code = !stop_code && ps.clk_sel != `CLOCK_SOURCE_SELECT_OSC_A && ps.clk_sel != `CLOCK_SOURCE_SELECT_OSC_B;
  // Stopped clock counts as standby, so no cycling then
  assign run = ps.cycle && !ps.sleep && !stop_code;
  assign base_end = base_cnt_ff == 32'(BASE_TICK_CYCLES - 1);
  assign tick_end = run && base_end && div_cnt_ff == ps.divider;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      use_pll_ff <= 1'b0;
      stopped_ff <= 1'b0;
    end else begin
      use_pll_ff <= auto_code && ps.pll_ready;
      stopped_ff <= stop_code;
    end
  end

  // Timing generator held at zero while not cycling or clock stopped
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      base_cnt_ff <= 32'h0000_0000;
      div_cnt_ff <= 8'h00;
    end else if (!run) begin
      base_cnt_ff <= 32'h0000_0000;
      div_cnt_ff <= 8'h00;
    end else if (base_end) begin
      base_cnt_ff <= 32'h0000_0000;
      div_cnt_ff <= (div_cnt_ff == ps.divider) ? 8'h00 : div_cnt_ff + 8'h01;
    end else begin
      base_cnt_ff <= base_cnt_ff + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wake_ff <= 1'b0;
      sample_ff <= 1'b0;
      dozing_ff <= 1'b0;
    end else begin
      wake_ff <= tick_end;
      sample_ff <= tick_end && !ps.all_standby;
      dozing_ff <= ps.sleep || (run && !tick_end);
    end
  end

  assign ps.wake = wake_ff;
  assign ps.sample = sample_ff;
  assign ps.use_pll = use_pll_ff;
  assign ps.stopped = stopped_ff;
  assign ps.dozing = dozing_ff;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  property p_no_sample;
    ps.wake && $past(ps.all_standby) |-> !ps.sample;
  endproperty
  a_no_sample: assert property (p_no_sample) else $error("sample with all axes off");
  property p_wake_run;
    ps.wake |-> $past(ps.cycle) && !$past(ps.sleep);
  endproperty
  a_wake_run: assert property (p_wake_run) else $error("wake while not cycling");
  property p_pll;
    ps.use_pll |-> $past(ps.pll_ready) && $past(ps.clk_sel) inside {[3'h1:3'h5]};
  endproperty
  a_pll: assert property (p_pll) else $error("pll used on wrong code");
  property p_stop;
    ps.clk_sel == `CLOCK_SOURCE_SELECT_STOP |=> ps.stopped && base_cnt_ff == 32'h0000_0000 && !ps.wake;
  endproperty
  a_stop: assert property (p_stop) else $error("timing ran with clock stopped");
endmodule // power_sequencer

// ===== logic/pwr_ctrl_if.sv
// Power configuration and sequencer status between the bank and the sequencer
`timescale 1ns/100ps
interface pwr_ctrl_if;
  logic sleep;
  logic cycle;
  logic all_standby;
  logic pll_ready;
  logic [2:0] clk_sel;
  logic [7:0] divider;
  logic wake;
  logic sample;
  logic use_pll;
  logic stopped;
  logic dozing;
  modport regs (output sleep, cycle, all_standby, pll_ready, clk_sel, divider,
                input wake, sample, use_pll, stopped, dozing);
  modport seq (input sleep, cycle, all_standby, pll_ready, clk_sel, divider,
               output wake, sample, use_pll, stopped, dozing);
endinterface

// ===== logic/sensor_ctrl_cfg.svh
// Offsets, field positions, reset values and timing counts of the control bank
`ifndef SENSOR_CTRL_CFG_SVH
`define SENSOR_CTRL_CFG_SVH
`define OFF_PATH 7'h68
`define OFF_MOTION 7'h69
`define OFF_IFC 7'h6a
`define OFF_PWR 7'h6b
`define OFF_STBY 7'h6c
`define BIT_ACCEL_RST 1
`define BIT_TEMP_RST 0
`define BIT_WOM_EN 7
`define BIT_WOM_MODE 6
`define BIT_FIFO_EN 6
`define BIT_SPI_ONLY 4
`define BIT_FIFO_RST 2
`define BIT_COND_RST 0
`define BIT_DEV_RST 7
`define BIT_SLEEP 6
`define BIT_CYCLE 5
`define BIT_THERMO_OFF 3
`define BIT_FIFO_LP 7
`define BIT_STBY_HI 5
`define BIT_STBY_LO 3
`define CLOCK_SOURCE_SELECT_RESET 3'h1
`define CLOCK_SOURCE_SELECT_OSC_A 3'h0
`define CLOCK_SOURCE_SELECT_OSC_B 3'h6
`define CLOCK_SOURCE_SELECT_STOP 3'h7
`define CLK_PERIOD_NS 10
`define FIFO_RST_NS 50
`define FIFO_RST_CYCLES ((`FIFO_RST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DEV_RST_CYCLES 4
`define BASE_TICK_NS 1000000
`define BASE_TICK_CYCLES (`BASE_TICK_NS / `CLK_PERIOD_NS)
`endif

// ===== logic/sensor_ctrl_pkg.sv
// Types shared by the control bank modules
package sensor_ctrl_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_DEVRST = 2'h2
  } dev_state_type;
endpackage

// ===== logic/sensor_reset_power_control.sv
// Reset, wake-on-motion, interface, power and clock source control registers
`timescale 1ns/100ps
`include "sensor_ctrl_cfg.svh"
module sensor_reset_power_control #(
  parameter int unsigned BASE_TICK_CYCLES = `BASE_TICK_CYCLES
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic pll_ready_i,
  input wire logic [7:0] sample_rate_divider_i,
  output logic accel_path_rst_o,
  output logic temp_path_rst_o,
  output logic result_clear_o,
  output logic motion_detect_enable_o,
  output logic motion_compare_select_o,
  output logic fifo_serial_enable_o,
  output logic spi_only_select_o,
  output logic fifo_rst_o,
  output logic device_reset_o,
  output logic sleep_o,
  output logic dozing_o,
  output logic thermo_sensor_off_o,
  output logic x_axis_standby_o,
  output logic y_axis_standby_o,
  output logic z_axis_standby_o,
  output logic fifo_low_power_o,
  output logic clock_use_pll_o,
  output logic clock_stopped_o,
  output logic wake_o,
  output logic sample_o
);
  sensor_ctrl_pkg::dev_state_type state_ff;
  logic [1:0] dev_cnt_ff;
  logic dev_rst_ff;
  logic pll_meta_ff;
  logic pll_sync_ff;
  logic [7:0] rdata_ff;
  logic accel_rst_ff;
  logic temp_rst_ff;
  logic result_clear_ff;
  logic wom_en_ff;
  logic wom_mode_ff;
  logic fifo_en_ff;
  logic spi_only_ff;
  logic [2:0] fifo_cnt_ff;
  logic fifo_rst_ff;
  logic sleep_ff;
  logic cycle_ff;
  logic thermo_off_ff;
  logic [2:0] clk_sel_ff;
  logic fifo_lp_ff;
  logic [2:0] stby_ff;
  logic idle;
  logic soft_rst;
  logic wr_path;
  logic wr_motion;
  logic wr_ifc;
  logic wr_pwr;
  logic wr_stby;
  logic wr_fifo_go;
  logic wr_cond;
  logic [2:0] nxt_fifo_cnt;

  pwr_ctrl_if pif ();

  // Writes during a device reset are dropped so defaults stick
  assign idle = state_ff == sensor_ctrl_pkg::ST_IDLE;
  assign soft_rst = state_ff == sensor_ctrl_pkg::ST_DEVRST;
  assign wr_path = reg_wr_i && idle && reg_addr_i == `OFF_PATH;
  assign wr_motion = reg_wr_i && idle && reg_addr_i == `OFF_MOTION;
  assign wr_ifc = reg_wr_i && idle && reg_addr_i == `OFF_IFC;
  assign wr_pwr = reg_wr_i && idle && reg_addr_i == `OFF_PWR;
  assign wr_stby = reg_wr_i && idle && reg_addr_i == `OFF_STBY;
  assign wr_fifo_go = wr_ifc && reg_wdata_i[`BIT_FIFO_RST];
  assign wr_cond = wr_ifc && reg_wdata_i[`BIT_COND_RST];

  // PLL status comes from another clock domain
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pll_meta_ff <= 1'b0;
      pll_sync_ff <= 1'b0;
    end else begin
      pll_meta_ff <= pll_ready_i;
      pll_sync_ff <= pll_meta_ff;
    end
  end

  // Device reset sequencer
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff <= sensor_ctrl_pkg::ST_IDLE;
      dev_cnt_ff <= 2'h0;
      dev_rst_ff <= 1'b0;
    end else begin
      unique case (state_ff)
        sensor_ctrl_pkg::ST_IDLE: begin
          if (wr_pwr && reg_wdata_i[`BIT_DEV_RST]) begin
            state_ff <= sensor_ctrl_pkg::ST_DEVRST;
            dev_cnt_ff <= 2'(`DEV_RST_CYCLES - 1);
            dev_rst_ff <= 1'b1;
          end
        end
        sensor_ctrl_pkg::ST_DEVRST: begin
          if (dev_cnt_ff == 2'h0) begin
            state_ff <= sensor_ctrl_pkg::ST_IDLE;
            dev_rst_ff <= 1'b0;
          end else begin
            dev_cnt_ff <= dev_cnt_ff - 2'h1;
          end
        end
      endcase
    end
  end

  // Path reset pulses; the path bits store nothing
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      accel_rst_ff <= 1'b0;
      temp_rst_ff <= 1'b0;
      result_clear_ff <= 1'b0;
    end else begin
      accel_rst_ff <= (wr_path && reg_wdata_i[`BIT_ACCEL_RST]) || wr_cond;
      temp_rst_ff <= (wr_path && reg_wdata_i[`BIT_TEMP_RST]) || wr_cond;
      result_clear_ff <= wr_cond;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wom_en_ff <= 1'b0;
      wom_mode_ff <= 1'b0;
    end else if (soft_rst) begin
      wom_en_ff <= 1'b0;
      wom_mode_ff <= 1'b0;
    end else if (wr_motion) begin
      wom_en_ff <= reg_wdata_i[`BIT_WOM_EN];
      // Host must keep this at 1; a 0 is stored but unsupported
      wom_mode_ff <= reg_wdata_i[`BIT_WOM_MODE];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fifo_en_ff <= 1'b0;
      spi_only_ff <= 1'b0;
    end else if (soft_rst) begin
      fifo_en_ff <= 1'b0;
      spi_only_ff <= 1'b0;
    end else if (wr_ifc) begin
      fifo_en_ff <= reg_wdata_i[`BIT_FIFO_EN];
      spi_only_ff <= reg_wdata_i[`BIT_SPI_ONLY];
    end
  end

  // FIFO reset lasts one internal 20 MHz period; a rewrite restarts it
  always_comb begin
    nxt_fifo_cnt = fifo_cnt_ff;
    if (wr_fifo_go) begin
      nxt_fifo_cnt = 3'(`FIFO_RST_CYCLES);
    end else if (fifo_cnt_ff != 3'h0) begin
      nxt_fifo_cnt = fifo_cnt_ff - 3'h1;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fifo_cnt_ff <= 3'h0;
      fifo_rst_ff <= 1'b0;
    end else begin
      fifo_cnt_ff <= nxt_fifo_cnt;
      fifo_rst_ff <= nxt_fifo_cnt != 3'h0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sleep_ff <= 1'b0;
      cycle_ff <= 1'b0;
      thermo_off_ff <= 1'b0;
      clk_sel_ff <= `CLOCK_SOURCE_SELECT_RESET;
    end else if (soft_rst) begin
      sleep_ff <= 1'b0;
      cycle_ff <= 1'b0;
      thermo_off_ff <= 1'b0;
      clk_sel_ff <= `CLOCK_SOURCE_SELECT_RESET;
    end else if (wr_pwr) begin
      sleep_ff <= reg_wdata_i[`BIT_SLEEP];
      cycle_ff <= reg_wdata_i[`BIT_CYCLE];
      thermo_off_ff <= reg_wdata_i[`BIT_THERMO_OFF];
      clk_sel_ff <= reg_wdata_i[2:0];
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fifo_lp_ff <= 1'b0;
      stby_ff <= 3'h0;
    end else if (soft_rst) begin
      fifo_lp_ff <= 1'b0;
      stby_ff <= 3'h0;
    end else if (wr_stby) begin
      fifo_lp_ff <= reg_wdata_i[`BIT_FIFO_LP];
      stby_ff <= reg_wdata_i[`BIT_STBY_HI:`BIT_STBY_LO];
    end
  end

  // Read data is held until the next read
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        `OFF_MOTION: rdata_ff <= {wom_en_ff, wom_mode_ff, 6'h00};
        `OFF_IFC: rdata_ff <= {1'b0, fifo_en_ff, 1'b0, spi_only_ff, 1'b0,
                               fifo_rst_ff, 2'h0};
        `OFF_PWR: rdata_ff <= {dev_rst_ff, sleep_ff, cycle_ff, 1'b0, thermo_off_ff,
                               clk_sel_ff};
        `OFF_STBY: rdata_ff <= {fifo_lp_ff, 1'b0, stby_ff, 3'h0};
        default: rdata_ff <= 8'h00;
      endcase
    end
  end

  assign pif.sleep = sleep_ff;
  assign pif.cycle = cycle_ff;
  assign pif.all_standby = &stby_ff;
  assign pif.pll_ready = pll_sync_ff;
  assign pif.clk_sel = clk_sel_ff;
  assign pif.divider = sample_rate_divider_i;

  power_sequencer #(
    .BASE_TICK_CYCLES(BASE_TICK_CYCLES)
  ) u_seq (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .ps(pif.seq)
  );

  assign reg_rdata_o = rdata_ff;
  assign accel_path_rst_o = accel_rst_ff;
  assign temp_path_rst_o = temp_rst_ff;
  assign result_clear_o = result_clear_ff;
  assign motion_detect_enable_o = wom_en_ff;
  assign motion_compare_select_o = wom_mode_ff;
  assign fifo_serial_enable_o = fifo_en_ff;
  assign spi_only_select_o = spi_only_ff;
  assign fifo_rst_o = fifo_rst_ff;
  assign device_reset_o = dev_rst_ff;
  assign sleep_o = sleep_ff;
  assign dozing_o = pif.dozing;
  assign thermo_sensor_off_o = thermo_off_ff;
  assign x_axis_standby_o = stby_ff[2];
  assign y_axis_standby_o = stby_ff[1];
  assign z_axis_standby_o = stby_ff[0];
  assign fifo_low_power_o = fifo_lp_ff;
  assign clock_use_pll_o = pif.use_pll;
  assign clock_stopped_o = pif.stopped;
  assign wake_o = pif.wake;
  assign sample_o = pif.sample;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  property p_accel_rst;
    wr_path && reg_wdata_i[`BIT_ACCEL_RST] |=> accel_path_rst_o ##1
      (!accel_path_rst_o || $past(wr_path && reg_wdata_i[`BIT_ACCEL_RST] || wr_cond));
  endproperty
  a_accel_rst: assert property (p_accel_rst) else $error("accel path reset wrong");
  property p_temp_rst;
    wr_path && reg_wdata_i[`BIT_TEMP_RST] |=> temp_path_rst_o ##1
      (!temp_path_rst_o || $past(wr_path && reg_wdata_i[`BIT_TEMP_RST] || wr_cond));
  endproperty
  a_temp_rst: assert property (p_temp_rst) else $error("temp path reset wrong");
  property p_keep_results;
    wr_path |=> !result_clear_o;
  endproperty
  a_keep_results: assert property (p_keep_results) else $error("results cleared");
  property p_wom;
    wr_motion |=> motion_detect_enable_o == $past(reg_wdata_i[7])
      && motion_compare_select_o == $past(reg_wdata_i[6]);
  endproperty
  a_wom: assert property (p_wom) else $error("motion control not stored");
  property p_ifc;
    wr_ifc |=> fifo_serial_enable_o == $past(reg_wdata_i[6])
      && spi_only_select_o == $past(reg_wdata_i[4]);
  endproperty
  a_ifc: assert property (p_ifc) else $error("interface control not stored");
  sequence s_fifo_hold;
    fifo_rst_o [*5];
  endsequence
  property p_fifo_rst;
    wr_fifo_go |=> s_fifo_hold;
  endproperty
  a_fifo_rst: assert property (p_fifo_rst) else $error("FIFO reset too short");
  property p_fifo_end;
    wr_fifo_go ##1 (!wr_fifo_go) [*5] |=> !fifo_rst_o;
  endproperty
  a_fifo_end: assert property (p_fifo_end) else $error("FIFO reset did not clear");
  property p_cond;
    wr_cond |=> result_clear_o && accel_path_rst_o && temp_path_rst_o;
  endproperty
  a_cond: assert property (p_cond) else $error("conditioning reset incomplete");
  sequence s_dev_hold;
    device_reset_o [*4] ##1 !device_reset_o;
  endsequence
  property p_dev_rst;
    wr_pwr && reg_wdata_i[`BIT_DEV_RST] |=> s_dev_hold ##0
      (clk_sel_ff == `CLOCK_SOURCE_SELECT_RESET && !sleep_ff && !wom_en_ff && !fifo_en_ff);
  endproperty
  a_dev_rst: assert property (p_dev_rst) else $error("device reset wrong");
  property p_sleep;
    wr_pwr && !reg_wdata_i[`BIT_DEV_RST] |=> sleep_o == $past(reg_wdata_i[6])
      && thermo_sensor_off_o == $past(reg_wdata_i[3]);
  endproperty
  a_sleep: assert property (p_sleep) else $error("power bits not stored");
  property p_stby;
    wr_stby |=> {x_axis_standby_o, y_axis_standby_o, z_axis_standby_o}
      == $past(reg_wdata_i[5:3]);
  endproperty
  a_stby: assert property (p_stby) else $error("standby bits not stored");
  property p_reserved;
    reg_rd_i && reg_addr_i == `OFF_MOTION |=> reg_rdata_o[5:0] == 6'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits nonzero");
  property p_poll;
    soft_rst ##1 idle |-> !dev_rst_ff;
  endproperty
  a_poll: assert property (p_poll) else $error("reset bit still set");
endmodule // sensor_reset_power_control

// ===== test/host_model.sv
// Host side model that reaches the control bank over its byte register port
`timescale 1ns/100ps
module host_model (
  input wire logic clk_i,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [6:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  input wire logic [7:0] reg_rdata_i
);
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_addr_o = 7'h00;
    reg_wdata_o = 8'h00;
  end

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_wr_o <= 1'b1;
    reg_addr_o <= a;
    // Wake-on-motion is never enabled with the unsupported compare mode
    reg_wdata_o <= (a == 7'h69 && d[7]) ? (d | 8'h40) : d;
    @(posedge clk_i);
    reg_wr_o <= 1'b0;
    // Released lines flip so a stale value is never mistaken for a held one
    reg_addr_o <= ~a;
    reg_wdata_o <= ~d;
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] q);
    @(posedge clk_i);
    reg_rd_o <= 1'b1;
    reg_addr_o <= a;
    @(posedge clk_i);
    reg_rd_o <= 1'b0;
    reg_addr_o <= ~a;
    #1;
    q = reg_rdata_i;
  endtask
endmodule // host_model

// ===== test/sensor_reset_power_control_tb_top.sv
// Self-checking bench for the reset, power and clock source control bank
`timescale 1ns/100ps
module sensor_reset_power_control_tb_top;
  localparam int unsigned TICK = 4;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic pll_ready_i = 1'b0;
  logic [7:0] div = 8'h01;
  logic wr, rd, acc, tmp, clr, mde, mcs, fse, spi, frst, dev, slp, doz, thm;
  logic sx, sy, sz, flp, use_pll, stopped, wake, smp;
  logic [6:0] addr;
  logic [7:0] wdata, rdata;
  int n_errors = 0;
  int num_checks = 0;
  int n;

  always #5 clk_i = ~clk_i;

  host_model host_u (.clk_i(clk_i), .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(addr),
    .reg_wdata_o(wdata), .reg_rdata_i(rdata));

  // Short base tick keeps duty-cycle periods to a handful of cycles
  sensor_reset_power_control #(.BASE_TICK_CYCLES(TICK)) dut_u (
    .clk_i(clk_i), .resetn_i(resetn_i), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_rdata_o(rdata), .pll_ready_i(pll_ready_i),
    .sample_rate_divider_i(div), .accel_path_rst_o(acc), .temp_path_rst_o(tmp),
    .result_clear_o(clr), .motion_detect_enable_o(mde), .motion_compare_select_o(mcs),
    .fifo_serial_enable_o(fse), .spi_only_select_o(spi), .fifo_rst_o(frst),
    .device_reset_o(dev), .sleep_o(slp), .dozing_o(doz), .thermo_sensor_off_o(thm),
    .x_axis_standby_o(sx), .y_axis_standby_o(sy), .z_axis_standby_o(sz),
    .fifo_low_power_o(flp), .clock_use_pll_o(use_pll), .clock_stopped_o(stopped),
    .wake_o(wake), .sample_o(smp));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] q;
    host_u.rd(a, q);
    chk(q, exp);
  endtask

  // Bounded wait: gives up after 100 cycles so a dead sequencer cannot hang
  task automatic wait_wake(output int k);
    k = 0;
    do begin
      @(posedge clk_i);
      #1;
      k++;
    end while (wake !== 1'b1 && k < 100);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #50000;
    n_errors++;
    $display("ERROR %0t watchdog expired", $time);
    finish_test();
  end

  initial begin
    repeat (16) @(posedge clk_i);
    resetn_i <= 1'b1;
    rchk(7'h68, 8'h00);
    rchk(7'h6b, 8'h01);
    host_u.wr(7'h10, 8'hff);
    rchk(7'h10, 8'h00);
    rchk(7'h69, 8'h00);
    $display("test reset values done");
    host_u.wr(7'h68, 8'hfe);
    #1 chk(8'({acc, tmp, clr}), 8'h04);
    @(posedge clk_i);
    #1 chk(8'({acc, tmp, clr}), 8'h00);
    host_u.wr(7'h68, 8'h01);
    #1 chk(8'({acc, tmp, clr}), 8'h02);
    host_u.wr(7'h6a, 8'h01);
    #1 chk(8'({acc, tmp, clr}), 8'h07);
    rchk(7'h6a, 8'h00);
    $display("test path resets done");
    host_u.wr(7'h69, 8'hff);
    rchk(7'h69, 8'hc0);
    chk(8'({mde, mcs}), 8'h03);
    host_u.wr(7'h69, 8'h40);
    #1 chk(8'({mde, mcs}), 8'h01);
    host_u.wr(7'h6a, 8'h54);
    #1 chk(8'({fse, spi, frst}), 8'h07);
    repeat (4) begin
      @(posedge clk_i);
      #1 chk(8'(frst), 8'h01);
    end
    @(posedge clk_i);
    #1 chk(8'(frst), 8'h00);
    rchk(7'h6a, 8'h50);
    $display("test motion and interface done");
    host_u.wr(7'h6b, 8'h48);
    #1 chk(8'({slp, thm}), 8'h03);
    rchk(7'h6b, 8'h48);
    chk(8'(doz), 8'h01);
    host_u.wr(7'h6b, 8'h80);
    #1 chk(8'(dev), 8'h01);
    repeat (3) begin
      @(posedge clk_i);
      #1 chk(8'(dev), 8'h01);
    end
    @(posedge clk_i);
    #1 chk(8'(dev), 8'h00);
    rchk(7'h6b, 8'h01);
    rchk(7'h6a, 8'h00);
    chk(8'({slp, fse, spi}), 8'h00);
    $display("test device reset done");
    @(posedge clk_i);
    pll_ready_i <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      host_u.wr(7'h6b, 8'(c));
      repeat (5) @(posedge clk_i);
      #1 chk(8'({use_pll, stopped}), 8'({(c >= 1 && c <= 5), (c == 7)}));
    end
    @(posedge clk_i);
    pll_ready_i <= 1'b0;
    host_u.wr(7'h6b, 8'h03);
    repeat (5) @(posedge clk_i);
    #1 chk(8'({use_pll, stopped}), 8'h00);
    $display("test clock source done");
    host_u.wr(7'h6c, 8'h00);
    host_u.wr(7'h6b, 8'h21);
    wait_wake(n);
    chk(8'({wake, smp, doz}), 8'h06);
    wait_wake(n);
    chk(8'(n), 8'(TICK * (div + 1)));
    host_u.wr(7'h6c, 8'hff);
    #1 chk(8'({flp, sx, sy, sz}), 8'h0f);
    wait_wake(n);
    wait_wake(n);
    chk(8'({wake, smp}), 8'h02);
    rchk(7'h6c, 8'hb8);
    host_u.wr(7'h6b, 8'h27);
    wait_wake(n);
    wait_wake(n);
    chk(8'(n), 8'd100);
    chk(8'(stopped), 8'h01);
    $display("test duty cycling done");
    finish_test();
  end
endmodule // sensor_reset_power_control_tb_top
